// ---- hw/crpss_pkg.sv ----
// Operation
// - While bus reset is active the device returns to a known state and drops both cache levels.
// - Every bus agent releases its bus outputs within two bus clocks of seeing bus reset active.
// - On the release edge of bus reset the device captures its strap pins as its configuration.
// - After release, unless straps chose tri-state, it may self-test and then fetches a vector.
// - An accepted management interrupt saves state, enters management mode and acknowledges.
// - A stop-clock request issues a stop-grant and gates core clocks, entering quick start.
// - In quick start the device keeps snooping and serving interrupts and the bus clock runs.
// - When stop-clock is removed and exit is allowed, core clocks restart and execution resumes.
// - With termination supply good the voltage-id outputs are driven to their final value.
package crpss_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SELFTEST_TIME_NS = 10000;
   localparam int SELFTEST_CYCLES = (SELFTEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] SELFTEST_LAST = CNT_W'(SELFTEST_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

   // reset vectors
   localparam logic [31:0] VECTOR_LOW = 32'h000F_FFF0;
   localparam logic [31:0] VECTOR_HIGH = 32'hFFFF_FFF0;
   localparam logic [31:0] VECTOR_NONE = 32'h0000_0000;

   // voltage id
   localparam int VID_W = 5;
   localparam logic [VID_W-1:0] VID_RELEASED = 5'h00;

   // special transaction codes
   localparam logic [1:0] TXN_NONE = 2'h0;
   localparam logic [1:0] TXN_SMI_ACK = 2'h1;
   localparam logic [1:0] TXN_STOP_GRANT = 2'h2;

   // strap layout, captured at reset release
   typedef struct packed {
      logic outputs_tristate;
      logic run_selftest;
      logic high_vector;
      logic [4:0] spare;
   } crpss_cfg_t;
   localparam crpss_cfg_t CFG_RESET = 8'h00;

   // special bus transaction request
   typedef struct packed {
      logic valid;
      logic [1:0] code;
   } crpss_txn_t;
   localparam crpss_txn_t TXN_IDLE = 3'h0;

   typedef enum logic [3:0] {
      ST_POWER_OFF,
      ST_RESET,
      ST_TRISTATE,
      ST_SELFTEST,
      ST_FETCH,
      ST_RUN,
      ST_SMM_SAVE,
      ST_SMM_ACK,
      ST_SMM,
      ST_STOP_GRANT,
      ST_QUICK_START
   } crpss_state_t;
endpackage : crpss_pkg

// ---- hw/crpss_seq.sv ----
`timescale 1ns/100ps
module crpss_seq
   import crpss_pkg::*;
#(
   parameter logic [VID_W-1:0] VID_CODE = 5'h0C
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // power and reset pins
   input wire logic power_stable_in,
   input wire logic bus_reset_n,
   input wire crpss_cfg_t cfg_pins,
   input wire logic term_supply_good,
   // interrupt and power-state requests
   input wire logic sys_mgmt_irq_n,
   input wire logic stop_clock_req_n,
   input wire logic quick_start_exit_ok,
   input wire logic smm_resume,
   // core and bus control
   output logic bus_out_en,
   output logic cache_invalidate,
   output logic core_clk_en,
   output logic bus_unit_clk_en,
   output logic snoop_en,
   output logic intr_service_en,
   output logic state_save,
   output crpss_txn_t special_txn,
   output logic fetch_start,
   output logic [31:0] fetch_addr,
   output logic built_in_selftest,
   output logic sys_mgmt_mode,
   output crpss_cfg_t config_out,
   // voltage id, open drain
   output logic [VID_W-1:0] voltage_id_out,
   output logic voltage_id_oe
);
   // synchroniser stages; stage one feeds stage two only
   logic pg_s1_reg, pg_s1_next, pg_s2_reg, pg_s2_next;
   logic smi_s1_reg, smi_s1_next, smi_s2_reg, smi_s2_next, smi_s3_reg, smi_s3_next;
   logic stp_s1_reg, stp_s1_next, stp_s2_reg, stp_s2_next;
   logic rst_n_d_reg, rst_n_d_next;
   logic smi_pend_reg, smi_pend_next;
   crpss_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic bus_out_en_reg, bus_out_en_next, inval_reg, inval_next;
   logic core_clk_reg, core_clk_next, bus_clk_reg, bus_clk_next;
   logic snoop_reg, snoop_next, intr_reg, intr_next, save_reg, save_next;
   crpss_txn_t txn_reg, txn_next;
   logic fetch_reg, fetch_next, built_in_selftest_reg, built_in_selftest_next, smm_reg, smm_next;
   logic [31:0] addr_reg, addr_next;
   crpss_cfg_t cfg_reg, cfg_next;
   logic [VID_W-1:0] vid_reg, vid_next;
   logic vid_oe_reg, vid_oe_next;
   logic smi_fall, rst_release, stop_req;

   // synchronisers; the clock may start after power-good is high, which only delays capture
   always_comb begin
      pg_s1_next = power_stable_in;
      pg_s2_next = pg_s1_reg;
      smi_s1_next = sys_mgmt_irq_n;
      smi_s2_next = smi_s1_reg;
      smi_s3_next = smi_s2_reg;
      stp_s1_next = stop_clock_req_n;
      stp_s2_next = stp_s1_reg;
      rst_n_d_next = bus_reset_n;
   end

   assign smi_fall = smi_s3_reg && !smi_s2_reg;
   assign rst_release = bus_reset_n && !rst_n_d_reg;
   assign stop_req = !stp_s2_reg;

   // sequencer next state and outputs
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      smi_pend_next = smi_pend_reg;
      bus_out_en_next = bus_out_en_reg;
      inval_next = 1'b0;
      core_clk_next = core_clk_reg;
      bus_clk_next = bus_clk_reg;
      snoop_next = snoop_reg;
      intr_next = intr_reg;
      save_next = 1'b0;
      txn_next = TXN_IDLE;
      fetch_next = 1'b0;
      addr_next = addr_reg;
      built_in_selftest_next = 1'b0;
      smm_next = smm_reg;
      cfg_next = cfg_reg;
      // an edge in the same cycle as the take keeps the request pending
      if (state_reg == ST_RUN && smi_pend_reg) begin
         smi_pend_next = 1'b0;
      end
      if (smi_fall) begin
         smi_pend_next = 1'b1;
      end
      case (state_reg)
         ST_POWER_OFF: begin
            if (pg_s2_reg) begin
               state_next = ST_RESET;
            end
         end
         ST_RESET: begin
            if (rst_release) begin
               cfg_next = cfg_pins;
               if (cfg_pins.outputs_tristate) begin
                  state_next = ST_TRISTATE;
               end else if (cfg_pins.run_selftest) begin
                  state_next = ST_SELFTEST;
                  cnt_next = CNT_ZERO;
                  built_in_selftest_next = 1'b1;
               end else begin
                  state_next = ST_FETCH;
               end
            end
         end
         ST_TRISTATE: begin
            bus_out_en_next = 1'b0;
         end
         ST_SELFTEST: begin
            built_in_selftest_next = (cnt_reg != SELFTEST_LAST);
            cnt_next = cnt_reg + CNT_ONE;
            if (cnt_reg == SELFTEST_LAST) begin
               state_next = ST_FETCH;
            end
         end
         ST_FETCH: begin
            fetch_next = 1'b1;
            addr_next = cfg_reg.high_vector ? VECTOR_HIGH : VECTOR_LOW;
            bus_out_en_next = 1'b1;
            core_clk_next = 1'b1;
            bus_clk_next = 1'b1;
            snoop_next = 1'b1;
            intr_next = 1'b1;
            state_next = ST_RUN;
         end
         ST_RUN: begin
            // management interrupt wins over a stop-clock request
            if (smi_pend_reg) begin
               state_next = ST_SMM_SAVE;
               save_next = 1'b1;
            end else if (stop_req) begin
               state_next = ST_STOP_GRANT;
            end
         end
         ST_SMM_SAVE: begin
            smm_next = 1'b1;
            txn_next = '{valid: 1'b1, code: TXN_SMI_ACK};
            state_next = ST_SMM_ACK;
         end
         ST_SMM_ACK: begin
            state_next = ST_SMM;
         end
         ST_SMM: begin
            if (smm_resume) begin
               smm_next = 1'b0;
               state_next = ST_RUN;
            end
         end
         ST_STOP_GRANT: begin
            txn_next = '{valid: 1'b1, code: TXN_STOP_GRANT};
            core_clk_next = 1'b0;
            state_next = ST_QUICK_START;
         end
         ST_QUICK_START: begin
            // bus unit, snoop and interrupt unit stay alive
            bus_clk_next = 1'b1;
            snoop_next = 1'b1;
            intr_next = 1'b1;
            if (!stop_req && quick_start_exit_ok) begin
               core_clk_next = 1'b1;
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_POWER_OFF;
         end
      endcase
      // bus reset overrides everything but power loss
      if (!bus_reset_n && state_reg != ST_POWER_OFF) begin
         state_next = ST_RESET;
         inval_next = 1'b1;
         bus_out_en_next = 1'b0;
         core_clk_next = 1'b0;
         bus_clk_next = 1'b0;
         snoop_next = 1'b0;
         intr_next = 1'b0;
         smm_next = 1'b0;
         smi_pend_next = 1'b0;
         cfg_next = CFG_RESET;
         addr_next = VECTOR_NONE;
         txn_next = TXN_IDLE;
         fetch_next = 1'b0;
         built_in_selftest_next = 1'b0;
         save_next = 1'b0;
      end
      // power loss returns to the idle state from anywhere
      if (!pg_s2_reg) begin
         state_next = ST_POWER_OFF;
         bus_out_en_next = 1'b0;
         core_clk_next = 1'b0;
         bus_clk_next = 1'b0;
         snoop_next = 1'b0;
         intr_next = 1'b0;
         smm_next = 1'b0;
         smi_pend_next = 1'b0;
         txn_next = TXN_IDLE;
         fetch_next = 1'b0;
         built_in_selftest_next = 1'b0;
         save_next = 1'b0;
      end
   end

   // voltage id is released until the termination supply is good
   always_comb begin
      vid_next = term_supply_good ? VID_CODE : VID_RELEASED;
      vid_oe_next = term_supply_good;
   end

   // all state freezes while the clock enable is low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pg_s1_reg <= 1'b0;
         pg_s2_reg <= 1'b0;
         smi_s1_reg <= 1'b1;
         smi_s2_reg <= 1'b1;
         smi_s3_reg <= 1'b1;
         stp_s1_reg <= 1'b1;
         stp_s2_reg <= 1'b1;
         rst_n_d_reg <= 1'b0;
         smi_pend_reg <= 1'b0;
         state_reg <= ST_POWER_OFF;
         cnt_reg <= CNT_ZERO;
         bus_out_en_reg <= 1'b0;
         inval_reg <= 1'b0;
         core_clk_reg <= 1'b0;
         bus_clk_reg <= 1'b0;
         snoop_reg <= 1'b0;
         intr_reg <= 1'b0;
         save_reg <= 1'b0;
         txn_reg <= TXN_IDLE;
         fetch_reg <= 1'b0;
         addr_reg <= VECTOR_NONE;
         built_in_selftest_reg <= 1'b0;
         smm_reg <= 1'b0;
         cfg_reg <= CFG_RESET;
         vid_reg <= VID_RELEASED;
         vid_oe_reg <= 1'b0;
      end else if (ce) begin
         pg_s1_reg <= pg_s1_next;
         pg_s2_reg <= pg_s2_next;
         smi_s1_reg <= smi_s1_next;
         smi_s2_reg <= smi_s2_next;
         smi_s3_reg <= smi_s3_next;
         stp_s1_reg <= stp_s1_next;
         stp_s2_reg <= stp_s2_next;
         rst_n_d_reg <= rst_n_d_next;
         smi_pend_reg <= smi_pend_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bus_out_en_reg <= bus_out_en_next;
         inval_reg <= inval_next;
         core_clk_reg <= core_clk_next;
         bus_clk_reg <= bus_clk_next;
         snoop_reg <= snoop_next;
         intr_reg <= intr_next;
         save_reg <= save_next;
         txn_reg <= txn_next;
         fetch_reg <= fetch_next;
         addr_reg <= addr_next;
         built_in_selftest_reg <= built_in_selftest_next;
         smm_reg <= smm_next;
         cfg_reg <= cfg_next;
         vid_reg <= vid_next;
         vid_oe_reg <= vid_oe_next;
      end
   end

   // outputs straight from flip-flops
   assign bus_out_en = bus_out_en_reg;
   assign cache_invalidate = inval_reg;
   assign core_clk_en = core_clk_reg;
   assign bus_unit_clk_en = bus_clk_reg;
   assign snoop_en = snoop_reg;
   assign intr_service_en = intr_reg;
   assign state_save = save_reg;
   assign special_txn = txn_reg;
   assign fetch_start = fetch_reg;
   assign fetch_addr = addr_reg;
   assign built_in_selftest = built_in_selftest_reg;
   assign sys_mgmt_mode = smm_reg;
   assign config_out = cfg_reg;
   assign voltage_id_out = vid_reg;
   assign voltage_id_oe = vid_oe_reg;

   // checks
   chk_reset_inval: assert property (@(posedge clk) disable iff (rst)
      (ce && !bus_reset_n && pg_s2_reg && state_reg != ST_POWER_OFF)
      |=> (cache_invalidate && state_reg == ST_RESET))
      else $error("bus reset did not invalidate caches");
   chk_bus_release: assert property (@(posedge clk) disable iff (rst)
      (ce && !bus_reset_n) |=> !bus_out_en)
      else $error("bus outputs not released under bus reset");
   chk_cfg_capture: assert property (@(posedge clk) disable iff (rst)
      (ce && pg_s2_reg && state_reg == ST_RESET && rst_release)
      |=> (config_out == $past(cfg_pins)))
      else $error("straps not captured at reset release");
   chk_fetch_vector: assert property (@(posedge clk) disable iff (rst)
      fetch_start |-> (!config_out.outputs_tristate && fetch_addr ==
      (config_out.high_vector ? VECTOR_HIGH : VECTOR_LOW)))
      else $error("fetch started at wrong vector or in tri-state");
   chk_smm_ack: assert property (@(posedge clk) disable iff (rst)
      (ce && pg_s2_reg && bus_reset_n && state_reg == ST_SMM_SAVE)
      |=> (sys_mgmt_mode && special_txn.valid && special_txn.code == TXN_SMI_ACK))
      else $error("management entry without acknowledge");
   chk_stop_grant: assert property (@(posedge clk) disable iff (rst)
      (ce && pg_s2_reg && bus_reset_n && state_reg == ST_STOP_GRANT)
      |=> (!core_clk_en && special_txn.code == TXN_STOP_GRANT && state_reg == ST_QUICK_START))
      else $error("stop grant entry wrong");
   chk_quick_alive: assert property (@(posedge clk) disable iff (rst)
      (state_reg == ST_QUICK_START) |-> (snoop_en && intr_service_en && bus_unit_clk_en))
      else $error("quick start lost snoop, interrupt or bus clock");
   chk_quick_exit: assert property (@(posedge clk) disable iff (rst)
      (ce && pg_s2_reg && bus_reset_n && state_reg == ST_QUICK_START && !stop_req
      && quick_start_exit_ok) |=> (core_clk_en && state_reg == ST_RUN))
      else $error("quick start exit did not restart core clocks");
   chk_vid_drive: assert property (@(posedge clk) disable iff (rst)
      (ce && term_supply_good) |=> (voltage_id_oe && voltage_id_out == VID_CODE))
      else $error("voltage id not driven with termination good");
   chk_pg_sync: assert property (@(posedge clk) disable iff (rst)
      (ce && $rose(pg_s2_reg)) |-> $past(power_stable_in, 2))
      else $error("power-good bypassed its synchroniser");
endmodule : crpss_seq

// ---- tb/crpss_sys_model.sv ----
`timescale 1ns/100ps
module crpss_sys_model
   import crpss_pkg::*;
#(
   parameter int RESET_CYCLES = 100000
) (
   // clock and commands from the bench
   input wire logic clk,
   input wire logic power_on,
   input wire logic reset_req,
   input wire logic vtt_on,
   // pins towards the device
   output logic power_stable_in,
   output logic bus_reset_n,
   output logic term_supply_good,
   output logic test_port_reset_n,
   // voltage id as the regulator sees it
   input wire logic [VID_W-1:0] voltage_id_out,
   input wire logic voltage_id_oe,
   output logic [VID_W-1:0] vid_latched
);
   int cnt_reg = RESET_CYCLES;
   initial begin
      power_stable_in = 1'b0;
      bus_reset_n = 1'b0;
      term_supply_good = 1'b0;
      test_port_reset_n = 1'b0;
      vid_latched = VID_RELEASED;
   end
   // power-good is one clean level; a power rise or a request restarts the full reset pulse
   always @(posedge clk) begin
      power_stable_in <= power_on;
      if (!power_on || reset_req || !power_stable_in) cnt_reg <= RESET_CYCLES;
      else if (cnt_reg != 0) cnt_reg <= cnt_reg - 1;
      bus_reset_n <= power_on && !reset_req && cnt_reg == 0;
      term_supply_good <= vtt_on;
      // the test port has no reset of its own, so hold it low through power-on reset
      test_port_reset_n <= power_on && cnt_reg == 0;
      // open drain lines float high when released; latch only once supply is good
      if (term_supply_good) vid_latched <= voltage_id_oe ? voltage_id_out : 5'h1F;
   end
endmodule : crpss_sys_model

// ---- tb/cpu_reset_power_state_seq_bench.sv ----
`timescale 1ns/100ps
module cpu_reset_power_state_seq_bench
   import crpss_pkg::*;
;
   localparam logic [VID_W-1:0] VID_SEL = 5'h13;
   logic clk, rst, ce, power_on, reset_req, vtt_on, power_stable_in, bus_reset_n;
   logic term_supply_good, sys_mgmt_irq_n, stop_clock_req_n, quick_start_exit_ok, smm_resume;
   logic bus_out_en, cache_invalidate, core_clk_en, bus_unit_clk_en, snoop_en;
   logic intr_service_en, state_save, fetch_start, built_in_selftest, sys_mgmt_mode;
   logic voltage_id_oe;
   logic [31:0] fetch_addr;
   logic [VID_W-1:0] voltage_id_out, vid_latched;
   crpss_cfg_t cfg_pins, config_out;
   crpss_txn_t special_txn;
   int errors = 0;
   int checked = 0;
   int cycles = 0;

   crpss_seq #(.VID_CODE(VID_SEL)) i_crpss_seq (.clk, .rst, .ce, .power_stable_in,
      .bus_reset_n, .cfg_pins, .term_supply_good, .sys_mgmt_irq_n, .stop_clock_req_n,
      .quick_start_exit_ok, .smm_resume, .bus_out_en, .cache_invalidate, .core_clk_en,
      .bus_unit_clk_en, .snoop_en, .intr_service_en, .state_save, .special_txn,
      .fetch_start, .fetch_addr, .built_in_selftest, .sys_mgmt_mode, .config_out,
      .voltage_id_out, .voltage_id_oe);
   // reset pulse shortened from 1 ms to keep the run brief
   crpss_sys_model #(.RESET_CYCLES(40)) i_crpss_sys_model (.clk, .power_on, .reset_req,
      .vtt_on, .power_stable_in, .bus_reset_n, .term_supply_good, .test_port_reset_n(),
      .voltage_id_out,
      .voltage_id_oe, .vid_latched);

   // clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("BAD %0t timeout", $time);
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk

   // steps land just after the edge so outputs are settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic complete_run();
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   task automatic t_vid();
      chk(voltage_id_oe, 1'b0, "vid driven early");
      @(posedge clk) vtt_on <= 1'b1;
      tick(3);
      chk(voltage_id_oe, 1'b1, "vid not driven");
      chk(voltage_id_out, VID_SEL, "vid value");
      tick(1);
      chk(vid_latched, VID_SEL, "vid seen by regulator");
   endtask : t_vid

   // bus reset pulse, then release with the given straps
   task automatic boot(input crpss_cfg_t cfg);
      int n;
      int b;
      @(posedge clk) begin
         cfg_pins <= cfg;
         power_on <= 1'b1;
         reset_req <= 1'b1;
      end
      tick(6);
      chk(cache_invalidate, 1'b1, "no invalidate in reset");
      chk(bus_out_en, 1'b0, "bus driven in reset");
      chk(fetch_start, 1'b0, "fetch in reset");
      @(posedge clk) reset_req <= 1'b0;
      n = 0;
      while (bus_reset_n !== 1'b1 && n < 500) begin
         tick(1);
         n++;
      end
      @(posedge clk) cfg_pins <= ~cfg; // straps change after release and must not matter
      #1;
      n = 1;
      b = 0;
      while (fetch_start !== 1'b1 && n < 1100) begin
         b += built_in_selftest;
         tick(1);
         n++;
      end
      chk(config_out, cfg, "straps not captured");
      if (cfg.outputs_tristate) begin
         chk(fetch_start, 1'b0, "fetch while tristate");
         chk(bus_out_en, 1'b0, "bus on while tristate");
      end else begin
         if (cfg.run_selftest) chk(b, SELFTEST_CYCLES, "selftest length");
         else chk(n, 2, "fetch timing");
         chk(fetch_addr, cfg.high_vector ? VECTOR_HIGH : VECTOR_LOW, "vector");
         chk({bus_out_en, core_clk_en, snoop_en}, 3'h7, "not running");
         tick(1);
         chk(fetch_start, 1'b0, "fetch pulse long");
         chk(cache_invalidate, 1'b0, "invalidate after release");
      end
   endtask : boot

   task automatic t_smi();
      int n;
      @(posedge clk) sys_mgmt_irq_n <= 1'b0;
      n = 0;
      while (state_save !== 1'b1 && n < 10) begin
         tick(1);
         n++;
      end
      chk(state_save, 1'b1, "no state save");
      tick(1);
      chk(sys_mgmt_mode, 1'b1, "no mgmt mode");
      chk(special_txn, {1'b1, TXN_SMI_ACK}, "no smi ack");
      tick(1);
      chk(special_txn, TXN_IDLE, "ack too long");
      @(posedge clk) begin
         sys_mgmt_irq_n <= 1'b1;
         smm_resume <= 1'b1;
      end
      tick(3);
      chk(sys_mgmt_mode, 1'b0, "mgmt mode stuck");
      @(posedge clk) smm_resume <= 1'b0;
   endtask : t_smi

   task automatic t_stop();
      int n;
      @(posedge clk) stop_clock_req_n <= 1'b0;
      n = 0;
      while (special_txn.valid !== 1'b1 && n < 10) begin
         tick(1);
         n++;
      end
      chk(special_txn, {1'b1, TXN_STOP_GRANT}, "no stop grant");
      chk(core_clk_en, 1'b0, "core clock runs");
      tick(5);
      chk({bus_unit_clk_en, snoop_en, intr_service_en}, 3'h7, "bus side stopped");
      @(posedge clk) stop_clock_req_n <= 1'b1;
      tick(6);
      chk(core_clk_en, 1'b0, "left without exit conditions");
      @(posedge clk) quick_start_exit_ok <= 1'b1;
      tick(3);
      chk(core_clk_en, 1'b1, "core clock not back");
   endtask : t_stop

   // a low clock enable holds every flop, even with bus reset asserted during the freeze
   task automatic t_freeze();
      @(posedge clk) begin
         ce <= 1'b0;
         reset_req <= 1'b1;
      end
      tick(6);
      chk({core_clk_en, cache_invalidate}, 2'h2, "state moved while frozen");
      @(posedge clk) ce <= 1'b1;
      tick(2);
      chk({core_clk_en, cache_invalidate}, 2'h1, "bus reset lost after freeze");
   endtask : t_freeze

   task automatic t_power_loss();
      @(posedge clk) power_on <= 1'b0;
      tick(5);
      chk({bus_out_en, core_clk_en}, 2'h0, "outputs on without power");
      // the model drops bus reset together with power, so the straps are cleared too
      chk(config_out, CFG_RESET, "config not cleared");
   endtask : t_power_loss

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      power_on = 1'b0;
      reset_req = 1'b0;
      vtt_on = 1'b0;
      cfg_pins = CFG_RESET;
      sys_mgmt_irq_n = 1'b1;
      stop_clock_req_n = 1'b1;
      quick_start_exit_ok = 1'b0;
      smm_resume = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      tick(2);
      chk(bus_out_en, 1'b0, "bus on before power");
      t_vid();
      boot(8'h00);
      t_smi();
      t_stop();
      t_freeze();
      boot(8'h60);
      boot(8'h80);
      boot(8'h40);
      t_power_loss();
      complete_run();
   end
endmodule : cpu_reset_power_state_seq_bench
